// >>> hw/baud_gen.sv
// Three-stage baud divider: fractional prescaler, then 11-bit divisor,
// then the oversampling or synchronous divide to the bit rate.
// Assumes configuration is only changed while the clock is stopped.
`timescale 1ns/1ps
`include "usart_consts.svh"
module baud_gen (
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  // Control side
  baud_if.gen       bus
);
  import usart_pkg::*;

  logic [5:0]  acc;
  logic        pre_tick;
  logic [10:0] div_cnt;
  logic [3:0]  ovs_cnt;

  // Terminal count of the final stage for the selected mode
  function automatic logic [3:0] ovs_last(input logic sync);
    return sync ? `OVS_SYNC : `OVS_ASYNC;
  endfunction

  // Prescaler in half-cycle units; lengths alternate for .5 factors
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc      <= 6'h00;
      pre_tick <= 1'b0;
    end else if (bus.restart || bus.prescale_sel == `PSEL_STOP) begin
      acc      <= 6'h00;
      pre_tick <= 1'b0;
    end else if (acc + 6'h02 >= {1'b0, bus.prescale_sel} + 6'h01) begin
      acc      <= acc + 6'h02 - ({1'b0, bus.prescale_sel} + 6'h01);
      pre_tick <= 1'b1;
    end else begin
      acc      <= acc + 6'h02;
      pre_tick <= 1'b0;
    end
  end

  // Divide by N, the programmed value plus one
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_cnt      <= 11'h000;
      bus.ovs_tick <= 1'b0;
    end else if (bus.restart || bus.prescale_sel == `PSEL_STOP) begin
      div_cnt      <= 11'h000; // Stopped clock restarts the divisor too
      bus.ovs_tick <= 1'b0;
    end else if (pre_tick && div_cnt == bus.divisor_m1) begin
      div_cnt      <= 11'h000;
      bus.ovs_tick <= 1'b1;
    end else begin
      div_cnt      <= pre_tick ? div_cnt + 11'h001 : div_cnt;
      bus.ovs_tick <= 1'b0;
    end
  end

  // Divide by 16 asynchronous, by 2 synchronous
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ovs_cnt      <= 4'h0;
      bus.bit_tick <= 1'b0;
    end else if (bus.restart || bus.prescale_sel == `PSEL_STOP) begin
      ovs_cnt      <= 4'h0; // New rate starts from a clean phase
      bus.bit_tick <= 1'b0;
    end else if (bus.ovs_tick && ovs_cnt >= ovs_last(bus.sync_mode)) begin
      ovs_cnt      <= 4'h0;
      bus.bit_tick <= 1'b1;
    end else begin
      ovs_cnt      <= bus.ovs_tick ? ovs_cnt + 4'h1 : ovs_cnt;
      bus.bit_tick <= 1'b0;
    end
  end
endmodule

// >>> hw/baud_if.sv
// Configuration and tick signals between the control block and the
// baud generator. Both ends run on the core clock.
`timescale 1ns/1ps
interface baud_if;
  logic [4:0]  prescale_sel;
  logic [10:0] divisor_m1;
  logic        sync_mode;
  logic        restart;
  logic        ovs_tick;
  logic        bit_tick;
  modport gen (input prescale_sel, divisor_m1, sync_mode, restart,
               output ovs_tick, bit_tick);
  modport ctl (output prescale_sel, divisor_m1, sync_mode, restart,
               input ovs_tick, bit_tick);
endinterface

// >>> hw/usart_baud_lowpower_attention.sv
// Serial port control: baud registers, transmit and receive holding
// and shift registers, loopback, address filter and halt/idle logic.
// Assumes a frame engine on the same clock issues load, shift and
// done strobes, and the chip issues the low-power entry strobe.
`timescale 1ns/1ps
`include "usart_consts.svh"

module usart_baud_lowpower_attention #(
  parameter int OSC_WAIT_CYCLES = `OSC_WAIT_CYCLES
) (
  // Clock and reset
  input  wire logic                i_core_clk,
  input  wire logic                i_rst_n,
  // Register port
  input  wire usart_pkg::reg_addr_t i_addr,
  input  wire usart_pkg::reg_data_t i_wdata,
  input  wire logic                i_wr,
  input  wire logic                i_rd,
  output      usart_pkg::reg_data_t o_rdata,
  // Frame engine strobes
  input  wire logic                i_tx_load,
  input  wire logic                i_tx_shift,
  input  wire logic                i_tx_line,
  input  wire logic                i_rx_shift,
  input  wire logic                i_rx_done,
  input  wire logic                i_frame_err,
  output      logic                o_tx_bit,
  output      logic                o_rx_line,
  output      logic                o_nine_bit_frame,
  output      logic                o_parity_off,
  output      logic                o_ovs_tick,
  output      logic                o_bit_tick,
  // Serial pins
  input  wire logic                i_serial_rx_pin,
  output      logic                o_serial_tx_pin,
  // Low-power control
  input  wire logic                i_lowpower_enter,
  input  wire logic                i_halt_mode,
  input  wire logic                i_crystal_osc,
  output      logic                o_wakeup,
  output      logic                o_exec_hold
);
  import usart_pkg::*;
  // Refuse a wait that the 16-bit counter cannot hold
  if (OSC_WAIT_CYCLES < 1 || OSC_WAIT_CYCLES > 65535) begin : g_bad_wait
    $error("OSC_WAIT_CYCLES out of range");
  end
  baud_if baud ();
  logic [4:0]   prescale_sel;
  logic [10:0]  divisor_m1;
  logic         char_length_sel_lo;
  logic         char_length_sel_hi;
  logic         tx_ninth_bit;
  logic         sync_mode;
  logic         address_filter_enable;
  logic         tx_buffer_empty_flag;
  logic         rx_buffer_full_flag;
  logic         rx_ninth_bit;
  logic         frame_err_flag;
  logic         overrun_flag;
  logic [7:0]   tx_holding_buffer;
  logic [8:0]   tx_shift_register;
  logic [7:0]   rx_holding_buffer;
  logic [8:0]   rx_shift_register;
  logic         rx_meta;
  logic         rx_sync;
  logic         rx_prev;
  logic         loopback;
  logic         rx_in;
  logic         reinit;
  logic         accept_char;
  logic         start_edge;
  logic         wr_rxctrl;
  logic         rd_rxbuf;
  logic [15:0]  wait_cnt;
  power_state_t state;
  reg_data_t    next_rdata;

  // Decode helper shared by the write and read paths
  function automatic logic hit(input reg_addr_t a, input reg_addr_t off);
    return a == off;
  endfunction

  // Baud generator hookup
  assign baud.prescale_sel = prescale_sel;
  assign baud.divisor_m1   = divisor_m1;
  assign baud.sync_mode    = sync_mode;
  assign baud.restart      = reinit;
  assign o_ovs_tick        = baud.ovs_tick;
  assign o_bit_tick        = baud.bit_tick;

  baud_gen u_baud_gen (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .bus        (baud)
  );
  // Strobe decodes and datapath steering
  assign reinit      = i_lowpower_enter && state == RUN;
  assign wr_rxctrl   = i_wr && hit(i_addr, `OFF_RXCTRL);
  assign rd_rxbuf    = i_rd && hit(i_addr, `OFF_RXBUF);
  assign loopback    = char_length_sel_lo && char_length_sel_hi;
  assign rx_in       = loopback ? tx_shift_register[0] : rx_sync;
  assign accept_char = i_rx_done &&
                       (!address_filter_enable ||
                        rx_shift_register[8]);
  assign start_edge  = rx_prev && !rx_sync;
  // Frame format hints for the frame engine
  assign o_nine_bit_frame = loopback ||
                            (char_length_sel_hi && !char_length_sel_lo);
  assign o_parity_off     = o_nine_bit_frame;
  assign o_tx_bit         = tx_shift_register[0];
  assign o_rx_line        = rx_in;
  assign o_serial_tx_pin  = loopback ? 1'b1 : i_tx_line;
  assign o_exec_hold      = state != RUN;
  // Receive pin synchroniser and edge history
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_meta <= i_serial_rx_pin;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
    end
  end
  // Baud divisor registers, cleared by reset, kept over halt/idle
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prescale_sel <= `PSEL_STOP;
      divisor_m1   <= 11'h000;
    end else if (i_wr && hit(i_addr, `OFF_PRESCALE)) begin
      prescale_sel <= i_wdata[`PSEL_MSB:`PSEL_LSB];
      divisor_m1   <= {i_wdata[`DIVHI_MSB:0], divisor_m1[7:0]};
    end else if (i_wr && hit(i_addr, `OFF_DIV_LO)) begin
      divisor_m1   <= {divisor_m1[10:8], i_wdata};
    end
  end
  // Read/write control bits survive reinitialisation
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      char_length_sel_lo <= 1'b0;
      char_length_sel_hi <= 1'b0;
      tx_ninth_bit       <= 1'b0;
      sync_mode          <= 1'b0;
    end else if (i_wr && hit(i_addr, `OFF_CTRL)) begin
      char_length_sel_lo <= i_wdata[`CTRL_CHL_LO];
      char_length_sel_hi <= i_wdata[`CTRL_CHL_HI];
      tx_ninth_bit       <= i_wdata[`CTRL_TX9];
      sync_mode          <= i_wdata[`CTRL_SYNC];
    end
  end
  // Attention bit: software sets, accepted address clears
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      address_filter_enable <= 1'b0;
    end else if (wr_rxctrl) begin
      address_filter_enable <= i_wdata[`RXC_ADDRESS_FILTER_ENABLE];
    end else if (accept_char && address_filter_enable) begin
      address_filter_enable <= 1'b0;
    end
  end
  // Transmit holding buffer is never touched by reinitialisation
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_holding_buffer <= `RST_BYTE;
    end else if (i_wr && hit(i_addr, `OFF_TXBUF)) begin
      tx_holding_buffer <= i_wdata;
    end
  end
  // Transmit-empty flag: hardware set wins over the software write
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_buffer_empty_flag <= 1'b1;
    end else if (reinit || i_tx_load) begin
      tx_buffer_empty_flag <= 1'b1;
    end else if (i_wr && hit(i_addr, `OFF_TXBUF)) begin
      tx_buffer_empty_flag <= 1'b0;
    end
  end
  // Transmit shifter, ninth bit from the control bit, ones shift in
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_shift_register <= `RST_TXSHIFT;
    end else if (reinit) begin
      tx_shift_register <= `RST_TXSHIFT;
    end else if (i_tx_load) begin
      tx_shift_register <= {tx_ninth_bit, tx_holding_buffer};
    end else if (i_tx_shift) begin
      tx_shift_register <= {1'b1, tx_shift_register[8:1]};
    end
  end
  // Receive shifter, fed from the pin or the loopback path
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_shift_register <= 9'h000;
    end else if (i_rx_shift) begin
      rx_shift_register <= {rx_in, rx_shift_register[8:1]};
    end
  end
  // Receive holding buffer keeps its contents over reinitialisation
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_holding_buffer <= `RST_BYTE;
    end else if (accept_char) begin
      rx_holding_buffer <= rx_shift_register[7:0];
    end
  end
  // Receive-full flag: arrival wins over the clearing read
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_buffer_full_flag <= 1'b0;
    end else if (reinit) begin
      rx_buffer_full_flag <= 1'b0;
    end else if (accept_char) begin
      rx_buffer_full_flag <= 1'b1;
    end else if (rd_rxbuf) begin
      rx_buffer_full_flag <= 1'b0;
    end
  end
  // Received ninth bit, read-only status
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_ninth_bit <= 1'b0;
    end else if (reinit) begin
      rx_ninth_bit <= 1'b0;
    end else if (accept_char) begin
      rx_ninth_bit <= rx_shift_register[8];
    end
  end
  // Error flags: events win, a write to their register clears them
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      frame_err_flag <= 1'b0;
      overrun_flag   <= 1'b0;
    end else if (reinit) begin
      frame_err_flag <= 1'b0;
      overrun_flag   <= 1'b0;
    end else begin
      frame_err_flag <= i_frame_err ||
                        (frame_err_flag && !wr_rxctrl);
      overrun_flag   <= (accept_char && rx_buffer_full_flag && !rd_rxbuf) ||
                        (overrun_flag && !wr_rxctrl);
    end
  end
  // Power state: sleep on entry, wake on start bit, oscillator wait
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state    <= RUN;
      wait_cnt <= 16'h0000;
      o_wakeup <= 1'b0;
    end else begin
      o_wakeup <= 1'b0;
      case (state)
        RUN: begin
          if (i_lowpower_enter) begin
            state <= LOW_POWER;
          end
        end
        LOW_POWER: begin
          if (start_edge) begin
            o_wakeup <= 1'b1;
            wait_cnt <= 16'h0000;
            state    <= (i_halt_mode && i_crystal_osc) ? OSC_WAIT : RUN;
          end
        end
        OSC_WAIT: begin
          if (wait_cnt == 16'(OSC_WAIT_CYCLES - 1)) begin
            state <= RUN;
          end else begin
            wait_cnt <= wait_cnt + 16'h0001;
          end
        end
        default: begin
          state <= RUN;
        end
      endcase
    end
  end
  // Read mux; unmapped words read zero
  always_comb begin
    next_rdata = `RST_BYTE;
    case (i_addr)
      `OFF_PRESCALE: next_rdata = {prescale_sel, divisor_m1[10:8]};
      `OFF_DIV_LO:   next_rdata = divisor_m1[7:0];
      `OFF_CTRL: begin
        next_rdata[`CTRL_CHL_LO] = char_length_sel_lo;
        next_rdata[`CTRL_CHL_HI] = char_length_sel_hi;
        next_rdata[`CTRL_TX9]    = tx_ninth_bit;
        next_rdata[`CTRL_SYNC]   = sync_mode;
        next_rdata[`CTRL_RX_BUFFER_FULL_FLAG]   = rx_buffer_full_flag;
        next_rdata[`CTRL_TX_BUFFER_EMPTY_FLAG]   = tx_buffer_empty_flag;
      end
      `OFF_RXCTRL: begin
        next_rdata[`RXC_ADDRESS_FILTER_ENABLE] = address_filter_enable;
        next_rdata[`RXC_RX9]  = rx_ninth_bit;
        next_rdata[`RXC_FERR] = frame_err_flag;
        next_rdata[`RXC_OERR] = overrun_flag;
      end
      `OFF_TXBUF:    next_rdata = tx_holding_buffer;
      `OFF_RXBUF:    next_rdata = rx_holding_buffer;
      default:       next_rdata = `RST_BYTE;
    endcase
  end
  // Read data registered, valid the cycle after the read strobe
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= `RST_BYTE;
    end else if (i_rd) begin
      o_rdata <= next_rdata;
    end
  end
endmodule

// >>> hw/usart_consts.svh
// Register offsets, field positions, reset values and timing figures
// for the serial port baud, low-power and address-filter block.
// Assumes an 8-bit register port with a 3-bit word address.
`ifndef USART_CONSTS_SVH
`define USART_CONSTS_SVH

// Register word addresses
`define OFF_PRESCALE      3'h0
`define OFF_DIV_LO        3'h1
`define OFF_CTRL          3'h2
`define OFF_RXCTRL        3'h3
`define OFF_TXBUF         3'h4
`define OFF_RXBUF         3'h5

// Prescaler register layout
`define PSEL_MSB          7
`define PSEL_LSB          3
`define DIVHI_MSB         2

// Serial control register bits
`define CTRL_CHL_LO       0
`define CTRL_CHL_HI       1
`define CTRL_TX9          2
`define CTRL_SYNC         3
`define CTRL_RX_BUFFER_FULL_FLAG         6
`define CTRL_TX_BUFFER_EMPTY_FLAG         7

// Receive control register bits
`define RXC_ADDRESS_FILTER_ENABLE          0
`define RXC_RX9           1
`define RXC_FERR          2
`define RXC_OERR          3

// Reset values
`define RST_BYTE          8'h00
`define RST_TXSHIFT       9'h1FF

// Divider figures
`define PSEL_STOP         5'h00
`define OVS_ASYNC         4'hF
`define OVS_SYNC          4'h1

// Oscillator start-up wait after a halt
`define CORE_CLK_NS       40
`define INSTR_CYCLE_NS    1000
`define OSC_WAIT_INSTR    256
`define OSC_WAIT_CYCLES   (`OSC_WAIT_INSTR * `INSTR_CYCLE_NS / `CORE_CLK_NS)

`endif

// >>> hw/usart_pkg.sv
// Types shared by the serial port block and its baud generator.
// Assumes the constants header is compiled alongside.
package usart_pkg;
  typedef logic [2:0] reg_addr_t;
  typedef logic [7:0] reg_data_t;
  typedef enum logic [1:0] {RUN, LOW_POWER, OSC_WAIT} power_state_t;
endpackage

// >>> testbench/serial_peer.sv
// Far-side processor on the serial line: idles high, sends start bits.
// Assumes the bench calls send_start from its main sequence.
`timescale 1ns/1ps
module serial_peer (
  // Clock
  input  wire logic i_core_clk,
  // Line
  input  wire logic i_line_in,
  output      logic o_line_out
);
  // Mark level between frames
  initial o_line_out = 1'b1;

  // Start bit of bit_len cycles, then back to mark
  task automatic send_start(input int bit_len);
    @(posedge i_core_clk) o_line_out <= 1'b0;
    repeat (bit_len) @(posedge i_core_clk);
    o_line_out <= 1'b1;
  endtask
endmodule

// >>> testbench/usart_baud_lowpower_attention_sva.sv
// Checker for the serial port baud, low-power and address-filter block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`include "usart_consts.svh"
module usart_baud_lowpower_attention_sva #(
  parameter int OSC_WAIT_CYCLES = `OSC_WAIT_CYCLES
) (
  // Clock and reset
  input wire logic                 i_core_clk,
  input wire logic                 i_rst_n,
  // Register port and strobes
  input wire usart_pkg::reg_addr_t i_addr,
  input wire usart_pkg::reg_data_t i_wdata,
  input wire logic                 i_wr,
  input wire logic                 i_rd,
  input wire usart_pkg::reg_data_t o_rdata,
  input wire logic                 i_tx_load,
  input wire logic                 i_tx_shift,
  input wire logic                 i_tx_line,
  // Outputs watched
  input wire logic                 o_tx_bit,
  input wire logic                 o_serial_tx_pin,
  input wire logic                 o_nine_bit_frame,
  input wire logic                 o_parity_off,
  input wire logic                 o_ovs_tick,
  input wire logic                 o_bit_tick,
  // Low-power control
  input wire logic                 i_lowpower_enter,
  input wire logic                 i_halt_mode,
  input wire logic                 i_crystal_osc,
  input wire logic                 o_wakeup,
  input wire logic                 o_exec_hold
);
  logic [4:0] sel_q;
  logic [1:0] chl_q;
  int         wake_age;

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  // Shadows of the prescaler select and length bits, from register writes
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel_q <= 5'h00;
      chl_q <= 2'b00;
    end else if (i_wr) begin
      if (i_addr == `OFF_PRESCALE)
        sel_q <= i_wdata[`PSEL_MSB:`PSEL_LSB];
      if (i_addr == `OFF_CTRL)
        chl_q <= {i_wdata[`CTRL_CHL_HI], i_wdata[`CTRL_CHL_LO]};
    end
  end

  // Cycles since a wakeup from halt with crystal, zero otherwise
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      wake_age <= 0;
    else if (o_wakeup && i_halt_mode && i_crystal_osc)
      wake_age <= 1;
    else if (wake_age != 0 && o_exec_hold)
      wake_age <= wake_age + 1;
    else
      wake_age <= 0;
  end

  a_stop_quiet: assert property ((sel_q == 5'h00)[*3] |-> !o_ovs_tick)
    else $error("oversample tick while the prescaler is stopped");
  a_bit_after_ovs: assert property (o_bit_tick |-> $past(o_ovs_tick))
    else $error("bit tick without a preceding oversample tick");
  a_bit_single: assert property (o_bit_tick |=> !o_bit_tick)
    else $error("bit tick lasted more than one cycle");
  a_nine_no_parity: assert property (chl_q == 2'b11
      |-> o_nine_bit_frame && o_parity_off)
    else $error("loopback frame not nine bits without parity");
  a_loop_pin_high: assert property (
      o_serial_tx_pin == (chl_q == 2'b11 || i_tx_line))
    else $error("transmit pin does not follow the loopback setting");
  a_enter_reinit: assert property (i_lowpower_enter && !o_exec_hold
      && !i_tx_load && !i_tx_shift |=> o_exec_hold && o_tx_bit)
    else $error("low-power entry did not hold execution or fill shifter");
  a_wake_pulse: assert property (o_wakeup |-> $past(o_exec_hold) ##1 !o_wakeup)
    else $error("wakeup pulse outside low power or too long");
  a_wake_idle_run: assert property (o_wakeup
      && !(i_halt_mode && i_crystal_osc) |-> !o_exec_hold)
    else $error("idle wakeup did not resume execution");
  // Hold lasts exactly the oscillator wait, counted from the pulse
  a_osc_wait_len: assert property (wake_age != 0
      |-> o_exec_hold == (wake_age < OSC_WAIT_CYCLES))
    else $error("oscillator wait after halt has the wrong length");
  a_unmapped_zero: assert property ($past(i_rd)
      && $past(i_addr) > 3'h5 |-> o_rdata == 8'h00)
    else $error("unmapped address read back non-zero");
endmodule

bind usart_baud_lowpower_attention usart_baud_lowpower_attention_sva #(
  .OSC_WAIT_CYCLES(OSC_WAIT_CYCLES)
) i_usart_baud_lowpower_attention_sva (
  .i_core_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
  .i_tx_load, .i_tx_shift, .i_tx_line, .o_tx_bit, .o_serial_tx_pin,
  .o_nine_bit_frame, .o_parity_off, .o_ovs_tick, .o_bit_tick,
  .i_lowpower_enter, .i_halt_mode, .i_crystal_osc, .o_wakeup, .o_exec_hold
);

// >>> testbench/usart_baud_lowpower_attention_tb.sv
// Self-checking bench for the serial port baud, low-power and filter block.
// Assumes the peer model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`include "usart_consts.svh"
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
  failures++; $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module usart_baud_lowpower_attention_tb;
  import usart_pkg::*;
  logic clk, rst_n, wr, rd, tx_load, tx_shift, tx_line, rx_shift;
  logic rx_done, frame_err, lp_enter, halt, xtal, rx_pin, tx_pin;
  logic tx_bit, rx_line, nine, par_off, ovs, bit_t, wake, hold, seen;
  reg_addr_t addr;
  reg_data_t wdata, rdata;
  int failures, check_count, cycles;

  usart_baud_lowpower_attention #(.OSC_WAIT_CYCLES(8))
    i_usart_baud_lowpower_attention (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_tx_load(tx_load),
    .i_tx_shift(tx_shift), .i_tx_line(tx_line), .i_rx_shift(rx_shift),
    .i_rx_done(rx_done), .i_frame_err(frame_err), .o_tx_bit(tx_bit),
    .o_rx_line(rx_line), .o_nine_bit_frame(nine), .o_parity_off(par_off),
    .o_ovs_tick(ovs), .o_bit_tick(bit_t), .i_serial_rx_pin(rx_pin),
    .o_serial_tx_pin(tx_pin), .i_lowpower_enter(lp_enter),
    .i_halt_mode(halt), .i_crystal_osc(xtal), .o_wakeup(wake),
    .o_exec_hold(hold));

  serial_peer i_serial_peer (.i_core_clk(clk), .i_line_in(tx_pin),
                             .o_line_out(rx_pin));

  // 25 MHz core clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Verdict and end of run
  task automatic give_verdict();
    if (failures == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic wr_reg(input reg_addr_t a, input reg_data_t d);
    @(posedge clk) addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
  endtask

  task automatic rd_chk(input reg_addr_t a, input reg_data_t e,
                        input string nm);
    @(posedge clk) addr <= a;
    rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    #1;
    `CHK(nm, e, rdata)
  endtask

  // Program a rate, then count ticks over a window
  task automatic baud(input logic [4:0] sel, input logic [2:0] dhi,
                      input reg_data_t dlo, input logic sy, input int win);
    integer n_ovs, n_bit, e_ovs, e_bit;
    n_ovs = 0;
    n_bit = 0;
    wr_reg(`OFF_PRESCALE, 8'h00);
    wr_reg(`OFF_DIV_LO, dlo);
    wr_reg(`OFF_CTRL, {4'h0, sy, 3'h0});
    wr_reg(`OFF_PRESCALE, {sel, dhi});
    e_ovs = (sel == 5'h00) ? 0 : win * 2 / ((sel + 1) * ({dhi, dlo} + 1));
    e_bit = e_ovs / (sy ? 2 : 16);
    repeat (40) @(posedge clk);
    repeat (win) begin
      @(posedge clk);
      #1;
      n_ovs = n_ovs + ovs;
      n_bit = n_bit + bit_t;
    end
    `CHK("ovs_count", 1'b1, (n_ovs >= e_ovs - 1 && n_ovs <= e_ovs + 1))
    `CHK("bit_count", 1'b1, (n_bit >= e_bit - 1 && n_bit <= e_bit + 1))
  endtask

  // One nine-bit character through the internal loop
  task automatic frame(input logic [8:0] ch);
    wr_reg(`OFF_TXBUF, ch[7:0]);
    wr_reg(`OFF_CTRL, {5'h00, ch[8], 2'b11});
    @(posedge clk) tx_load <= 1'b1;
    @(posedge clk) tx_load <= 1'b0;
    tx_shift <= 1'b1;
    rx_shift <= 1'b1;
    #1;
    `CHK("rx_loop", ch[0], rx_line)
    repeat (9) @(posedge clk);
    tx_shift <= 1'b0;
    rx_shift <= 1'b0;
    rx_done <= 1'b1;
    @(posedge clk) rx_done <= 1'b0;
  endtask

  // Enter low power, send a start bit, wait for the wakeup pulse
  task automatic sleep_wake();
    @(posedge clk) lp_enter <= 1'b1;
    @(posedge clk) lp_enter <= 1'b0;
    #1;
    `CHK("hold", 1'b1, hold)
    `CHK("tx_fill", 1'b1, tx_bit)
    seen = 1'b0;
    // The pulse lasts one cycle, so watch while the start bit is sent
    fork
      i_serial_peer.send_start(4);
      repeat (20) begin
        @(posedge clk);
        #1;
        seen = wake;
        if (seen === 1'b1) break;
      end
    join
    `CHK("wakeup", 1'b1, seen)
  endtask

  // Main sequence
  initial begin
    {rst_n, wr, rd, tx_load, tx_shift, tx_line, rx_shift} = '0;
    {rx_done, frame_err, lp_enter, halt, xtal, addr, wdata} = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 8; a++)
      rd_chk(a[2:0], (a == 2) ? 8'h80 : 8'h00, "reset_value");
    baud(5'h00, 3'h0, 8'h00, 1'b0, 100);
    baud(5'h01, 3'h0, 8'h00, 1'b0, 320);
    baud(5'h02, 3'h0, 8'h01, 1'b0, 960);
    baud(5'h1F, 3'h0, 8'h00, 1'b1, 640);
    baud(5'h04, 3'h1, 8'h00, 1'b0, 6425);
    `CHK("pin_follows", 1'b0, tx_pin)
    wr_reg(`OFF_PRESCALE, 8'h00);
    wr_reg(`OFF_RXCTRL, 8'h01);
    frame(9'h055);
    `CHK("pin_loop_high", 1'b1, tx_pin)
    `CHK("nine_no_parity", 2'b11, {nine, par_off})
    rd_chk(`OFF_CTRL, 8'h83, "data_dropped");
    frame(9'h1A5);
    rd_chk(`OFF_CTRL, 8'hC7, "addr_full");
    rd_chk(`OFF_RXCTRL, 8'h02, "address_filter_enable_cleared");
    rd_chk(`OFF_RXBUF, 8'hA5, "addr_char");
    frame(9'h03C);
    rd_chk(`OFF_RXBUF, 8'h3C, "data_after");
    frame(9'h011);
    frame(9'h122);
    @(posedge clk) frame_err <= 1'b1;
    @(posedge clk) frame_err <= 1'b0;
    rd_chk(`OFF_RXCTRL, 8'h0E, "errors_set");
    wr_reg(`OFF_RXCTRL, 8'h00);
    rd_chk(`OFF_RXCTRL, 8'h02, "errors_cleared");
    wr_reg(`OFF_RXCTRL, 8'h01);
    @(posedge clk) frame_err <= 1'b1;
    @(posedge clk) frame_err <= 1'b0;
    wr_reg(`OFF_TXBUF, 8'h5A);
    @(posedge clk) tx_load <= 1'b1;
    @(posedge clk) tx_load <= 1'b0;
    wr_reg(`OFF_TXBUF, 8'h5A);
    `CHK("tx_loaded", 1'b0, tx_bit)
    sleep_wake();
    `CHK("idle_run", 1'b0, hold)
    rd_chk(`OFF_CTRL, 8'h87, "reinit_ctrl");
    rd_chk(`OFF_RXCTRL, 8'h01, "reinit_rxctrl");
    rd_chk(`OFF_TXBUF, 8'h5A, "txbuf_kept");
    rd_chk(`OFF_RXBUF, 8'h22, "rxbuf_kept");
    halt <= 1'b1;
    xtal <= 1'b1;
    sleep_wake();
    repeat (4) @(posedge clk);
    #1;
    `CHK("osc_wait", 1'b1, hold)
    repeat (6) @(posedge clk);
    #1;
    `CHK("osc_done", 1'b0, hold)
    give_verdict();
  end
endmodule
